// file: sim/log_host_model.sv
module log_host_model (
  input  wire logic                      i_clk,
  input  wire logic                      i_req_ready,
  input  wire logic                      i_req_reject,
  input  wire logic [7:0]                i_byte,
  input  wire logic                      i_byte_valid,
  input  wire logic                      i_byte_last,
  output stream_log_pkg::log_req_s       o_req,
  output logic                           o_byte_ready,
  output logic                           o_cmd_done,
  output logic                           o_cmd_good
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] page [512];
  int         got;
  int         last_at;
  logic       rejected;

  initial
  begin
    o_req        = '0;
    o_byte_ready = 1'b0;
    o_cmd_done   = 1'b0;
    o_cmd_good   = 1'b0;
  end

  // Hold the request until the keeper shows ready, then release it
  task automatic ask(input logic [7:0] addr);
    int w;
    w = 0;
    o_req = '{valid: 1'b1, log_addr: addr};
    while (i_req_ready !== 1'b1 && w < 2000)
    begin
      @(negedge i_clk);
      w++;
    end
    @(negedge i_clk);
    o_req = '{valid: 1'b0, log_addr: ~addr};
    rejected = i_req_reject;
  endtask

  // Fetch one page, stalling when slow, then report completion
  task automatic read_page(input logic [7:0] addr, input bit slow, input logic good);
    int t;
    t = 0;
    got = 0;
    last_at = -1;
    @(negedge i_clk);
    ask(addr);
    while (got < 512 && t < 4000)
    begin
      o_byte_ready = !slow || t[1];
      if (i_byte_valid === 1'b1 && o_byte_ready)
      begin
        page[got] = i_byte;
        if (i_byte_last === 1'b1)
          last_at = got;
        got++;
      end
      t++;
      @(negedge i_clk);
    end
    o_byte_ready = 1'b0;
    repeat (slow ? 5 : 1) @(negedge i_clk);
    o_cmd_done = 1'b1;
    o_cmd_good = good;
    @(negedge i_clk);
    o_cmd_done = 1'b0;
    o_cmd_good = ~good;
    t = 0;
    while (i_req_ready !== 1'b1 && t < 100)
    begin
      @(negedge i_clk);
      t++;
    end
  endtask
endmodule

// file: sim/test_stream_error_log_keeper.sv
module test_stream_error_log_keeper;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [63:0] SECT_T = 64'h1357_0000_00ab_cdef;
  localparam logic [63:0] POS_T  = 64'h0000_0000_0042_1001;
  localparam logic [31:0] ACC_T  = 32'h0200_0010;

  logic                        clk = 1'b0;
  logic                        reset;
  stream_log_pkg::stream_err_s evt;
  stream_log_pkg::log_req_s    req;
  logic                        req_ready;
  logic                        req_reject;
  logic [7:0]                  byte_q;
  logic                        byte_valid;
  logic                        byte_last;
  logic                        byte_ready;
  logic                        cmd_done;
  logic                        cmd_good;
  logic [4:0]                  w_idx;
  logic [15:0]                 w_cnt;
  logic [4:0]                  r_idx;
  logic [15:0]                 r_cnt;
  int                          n_mismatch = 0;
  int                          compares = 0;
  int                          cycles = 0;

  always #20 clk = ~clk;

  stream_error_log_keeper #(.SECT_TABLE(SECT_T), .POS_TABLE(POS_T), .ACC_TABLE(ACC_T)) DUT (
    .i_clk(clk), .i_reset(reset), .i_evt(evt), .i_req(req), .o_req_ready(req_ready),
    .o_req_reject(req_reject), .o_byte(byte_q), .o_byte_valid(byte_valid),
    .o_byte_last(byte_last), .i_byte_ready(byte_ready), .i_cmd_done(cmd_done),
    .i_cmd_good(cmd_good), .o_write_index(w_idx), .o_write_count(w_cnt),
    .o_read_index(r_idx), .o_read_count(r_cnt));

  log_host_model host (
    .i_clk(clk), .i_req_ready(req_ready), .i_req_reject(req_reject), .i_byte(byte_q),
    .i_byte_valid(byte_valid), .i_byte_last(byte_last), .o_req(req),
    .o_byte_ready(byte_ready), .o_cmd_done(cmd_done), .o_cmd_good(cmd_good));

  task automatic end_of_test;
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic check(input logic [20:0] seen, input logic [20:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic stream_log_pkg::stream_err_s mk(input logic w, input logic d,
                                                     input logic [7:0] k);
    stream_log_pkg::stream_err_s e;
    e = '{valid: 1'b1, is_write: w, deferred: d, feat_cur: k, feat_prev: ~k,
          status: 8'h21, error: 8'h04 ^ k, lba: {8'h5a, 8'h3c, 24'h0, k},
          nsect: {k, 8'h81}};
    return e;
  endfunction

  task automatic send(input stream_log_pkg::stream_err_s e);
    evt = e;
    @(negedge clk);
    evt = '0;
  endtask

  task automatic zero(input int a, input int b);
    for (int i = a; i <= b; i++)
      check(host.page[i], 16'h0);
  endtask

  task automatic head(input logic [4:0] idx, input logic [15:0] cnt);
    check(host.got, 16'd512);
    check(host.last_at, 16'd511);
    check(host.page[0], 16'h02);
    check(host.page[1], idx);
    check({host.page[3], host.page[2]}, cnt);
    zero(4, 15);
  endtask

  task automatic entry(input int n, input stream_log_pkg::stream_err_s e);
    logic [15:0] f;
    f = e.deferred ? 16'hffff : {e.feat_prev, e.feat_cur};
    check({host.page[n*16+1], host.page[n*16]}, f);
    check(host.page[n*16+2], e.status);
    check(host.page[n*16+3], e.error);
    for (int i = 0; i < 6; i++)
      check(host.page[n*16+4+i], e.lba[8*i+:8]);
    check({host.page[n*16+13], host.page[n*16+12]}, e.nsect);
    zero(n*16+10, n*16+11);
    zero(n*16+14, n*16+15);
  endtask

  task automatic s_reset;
    check({r_idx, w_idx, 6'h0}, 16'h0);
    check(r_cnt | w_cnt, 16'h0);
    host.read_page(8'h22, 1'b0, 1'b1);
    head(5'd0, 16'd0);
    zero(16, 511);
  endtask

  task automatic s_logging;
    stream_log_pkg::stream_err_s quiet;
    quiet = mk(1'b0, 1'b0, 8'h07);
    quiet.status = 8'hdf;
    send(mk(1'b0, 1'b0, 8'h11));
    send(quiet);
    send(mk(1'b1, 1'b1, 8'h22));
    send(mk(1'b1, 1'b0, 8'h33));
    check({r_idx, r_cnt[7:0]}, {5'd1, 8'd1});
    check({w_idx, w_cnt[7:0]}, {5'd2, 8'd2});
    host.read_page(8'h21, 1'b1, 1'b1);
    head(5'd2, 16'd2);
    entry(1, mk(1'b1, 1'b1, 8'h22));
    entry(2, mk(1'b1, 1'b0, 8'h33));
    zero(48, 511);
    check({w_idx, w_cnt}, 21'h0);
    check(r_idx, 16'd1);
    host.read_page(8'h22, 1'b0, 1'b1);
    head(5'd1, 16'd1);
    entry(1, mk(1'b0, 1'b0, 8'h11));
    check({r_idx, r_cnt}, 21'h0);
  endtask

  task automatic s_wrap;
    for (int k = 1; k <= 33; k++)
    begin
      evt = mk(1'b0, 1'b0, 8'(k));
      @(negedge clk);
    end
    evt = '0;
    @(negedge clk);
    check({r_idx, r_cnt}, {5'd2, 16'd33});
    host.read_page(8'h22, 1'b0, 1'b0);
    head(5'd2, 16'd33);
    entry(1, mk(1'b0, 1'b0, 8'd32));
    entry(2, mk(1'b0, 1'b0, 8'd33));
    entry(31, mk(1'b0, 1'b0, 8'd31));
    check(r_cnt, 16'd33);
    host.read_page(8'h22, 1'b1, 1'b1);
    check({r_idx, r_cnt}, 21'h0);
  endtask

  task automatic s_saturate;
    evt = mk(1'b0, 1'b0, 8'h01);
    repeat (65537) @(negedge clk);
    send(mk(1'b1, 1'b0, 8'h02));
    check(r_cnt, 16'hffff);
    check(r_idx, 16'd3);
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    check({r_idx, w_idx, 6'h0}, 16'h0);
    check(r_cnt | w_cnt, 16'h0);
  endtask

  task automatic s_pages;
    host.read_page(8'h00, 1'b1, 1'b1);
    check({host.page[1], host.page[0]}, 16'h0001);
    zero(2, 63);
    for (int i = 0; i < 3; i++)
      check({host.page[65+2*i], host.page[64+2*i]}, 16'h0001);
    zero(70, 511);
    host.read_page(8'h20, 1'b0, 1'b1);
    check({host.page[1], host.page[0]}, stream_log_pkg::PERF_VERSION);
    for (int i = 1; i < 4; i++)
      check({host.page[2*i+1], host.page[2*i]}, 16'h0001);
    for (int i = 0; i < 8; i++)
      check({host.page[16+i], host.page[8+i]}, {POS_T[8*i+:8], SECT_T[8*i+:8]});
    for (int i = 0; i < 4; i++)
      check(host.page[24+i], ACC_T[8*i+:8]);
    zero(28, 511);
    @(negedge clk);
    host.ask(8'h23);
    check({req_reject, host.rejected}, 16'h3);
    check(req_ready, 16'h1);
    @(negedge clk);
    check(req_reject, 16'h0);
  endtask

  initial
  begin
    reset = 1'b1;
    evt = '0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    s_reset();
    s_logging();
    s_wrap();
    s_saturate();
    s_pages();
    end_of_test();
  end
endmodule

// file: verilog/stream_error_log_keeper.sv
// Overview of operation
// - Log only commands with stream error flag
// - At most 31 entries, newest kept
// - Read counter counts errors since 22h read
// - Read counter saturates at maximum
// - Good 22h read clears read log
// - Reset empties both logs
// - Header: version, index, count, 16-byte entries
// - Version byte reads 02h
// - Count field reports errors, may exceed 31
// - Read index points newest, 0 to 31
// - Entry: features, status, error bytes
// - Deferred write stores FFFFh features
// - Entry holds 48-bit address and length
// - Write counter counts errors since 21h read
// - Write counter saturates at maximum
// - Good 21h read clears write log
// - Write entries at 10h, 20h ... 1F0h
// - Write index ranges 0 to 31
// - Performance page at 20h, length in directory
// - Performance page: header then three arrays
// - Sector time entry: address then time
// - Access time entry: difference then time
module stream_error_log_keeper #(
  parameter int            K_REGIONS   = 1,
  parameter int            L_POSITIONS = 1,
  parameter int            M_DIFFS     = 1,
  parameter logic [K_REGIONS*64-1:0]   SECT_TABLE = '0,
  parameter logic [L_POSITIONS*64-1:0] POS_TABLE  = '0,
  parameter logic [M_DIFFS*32-1:0]     ACC_TABLE  = '0
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_reset,
  input  wire stream_log_pkg::stream_err_s i_evt,
  input  wire stream_log_pkg::log_req_s    i_req,
  output logic                             o_req_ready,
  output logic                             o_req_reject,
  output logic      [7:0]                  o_byte,
  output logic                             o_byte_valid,
  output logic                             o_byte_last,
  input  wire logic                        i_byte_ready,
  input  wire logic                        i_cmd_done,
  input  wire logic                        i_cmd_good,
  output logic      [4:0]                  o_write_index,
  output logic      [15:0]                 o_write_count,
  output logic      [4:0]                  o_read_index,
  output logic      [15:0]                 o_read_count
);

  localparam int SECT_END = stream_log_pkg::PERF_HDR_BYTES
                          + K_REGIONS * stream_log_pkg::SECT_ENTRY_BYTES;
  localparam int POS_END  = SECT_END + L_POSITIONS * stream_log_pkg::POS_ENTRY_BYTES;
  localparam int ACC_END  = POS_END + M_DIFFS * stream_log_pkg::ACC_ENTRY_BYTES;
  localparam logic [8:0] PAGE_LAST = stream_log_pkg::PAGE_LAST;

  localparam logic [63:0] PERF_HDR = {16'(M_DIFFS), 16'(L_POSITIONS), 16'(K_REGIONS),
                                      stream_log_pkg::PERF_VERSION};

  stream_log_pkg::serve_state_e state_q;
  logic [7:0]                   sel_q;
  logic [8:0]                   ptr_q;
  logic [7:0]                   byte_q;
  logic                         reject_q;
  logic [8:0]                   fetch_ptr;
  logic [7:0]                   page_byte;
  logic [7:0]                   store_byte [2];
  logic [4:0]                   store_index [2];
  logic [15:0]                  store_count [2];
  logic [1:0]                   clear;
  logic                         addr_ok;
  logic                         advance;

  // Directory page: word 0 holds the version, then one word per log address giving its length in sectors
  function automatic logic [7:0] dir_byte(input logic [8:0] ofs);
    logic [15:0] word;
    word = 16'h0000;
    case (ofs[8:1])
      8'h00:                           word = stream_log_pkg::DIR_VERSION;
      stream_log_pkg::LOG_PERF:        word = stream_log_pkg::PERF_SECTORS;
      stream_log_pkg::LOG_WRITE_STREAM: word = stream_log_pkg::STREAM_LOG_SECTORS;
      stream_log_pkg::LOG_READ_STREAM: word = stream_log_pkg::STREAM_LOG_SECTORS;
      default:                         word = 16'h0000;
    endcase
    return ofs[0] ? word[15:8] : word[7:0];
  endfunction

  // Performance page: header, sector time, position and access time arrays
  function automatic logic [7:0] perf_byte(input logic [8:0] ofs);
    int i;
    i = int'(ofs);
    if (i < stream_log_pkg::PERF_HDR_BYTES)
      return PERF_HDR[i*8 +: 8];
    else if (i < SECT_END)
      return SECT_TABLE[(i - stream_log_pkg::PERF_HDR_BYTES)*8 +: 8];
    else if (i < POS_END)
      return POS_TABLE[(i - SECT_END)*8 +: 8];
    else if (i < ACC_END)
      return ACC_TABLE[(i - POS_END)*8 +: 8];
    else
      return 8'h00;
  endfunction

  // Both stream logs; index 0 is the write log, index 1 the read log
  for (genvar g = 0; g < 2; g++)
  begin : g_log
    localparam logic [7:0] ADDR = (g == 0) ? stream_log_pkg::LOG_WRITE_STREAM
                                           : stream_log_pkg::LOG_READ_STREAM;

    // A good completed read of this log resets it
    assign clear[g] = state_q == stream_log_pkg::ST_END && i_cmd_done && i_cmd_good
                      && sel_q == ADDR;

    stream_log_store #(
      .ENTRIES (stream_log_pkg::MAX_ENTRIES)
    ) u_store (
      .i_clk    (i_clk),
      .i_reset  (i_reset),
      .i_log    (i_evt.valid && (i_evt.is_write == (g == 0))),
      .i_evt    (i_evt),
      .i_clear  (clear[g]),
      .i_offset (fetch_ptr),
      .o_byte   (store_byte[g]),
      .o_index  (store_index[g]),
      .o_count  (store_count[g])
    );
  end

  assign addr_ok = i_req.log_addr == stream_log_pkg::LOG_DIRECTORY
                || i_req.log_addr == stream_log_pkg::LOG_PERF
                || i_req.log_addr == stream_log_pkg::LOG_WRITE_STREAM
                || i_req.log_addr == stream_log_pkg::LOG_READ_STREAM;

  assign advance   = state_q == stream_log_pkg::ST_SEND && i_byte_ready && ptr_q != PAGE_LAST;
  assign fetch_ptr = (state_q == stream_log_pkg::ST_SEND) ? ptr_q + 9'h001 : 9'h000;

  always_comb
  begin
    case (sel_q)
      stream_log_pkg::LOG_DIRECTORY:    page_byte = dir_byte(fetch_ptr);
      stream_log_pkg::LOG_PERF:         page_byte = perf_byte(fetch_ptr);
      stream_log_pkg::LOG_WRITE_STREAM: page_byte = store_byte[0];
      stream_log_pkg::LOG_READ_STREAM:  page_byte = store_byte[1];
      default:                          page_byte = 8'h00;
    endcase
  end

  // Serving sequence
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      state_q <= stream_log_pkg::ST_IDLE;
    else
    begin
      case (state_q)
        stream_log_pkg::ST_IDLE:
          if (i_req.valid && addr_ok)
            state_q <= stream_log_pkg::ST_LOAD;
        stream_log_pkg::ST_LOAD:
          state_q <= stream_log_pkg::ST_SEND;
        stream_log_pkg::ST_SEND:
          if (i_byte_ready && ptr_q == PAGE_LAST)
            state_q <= stream_log_pkg::ST_END;
        stream_log_pkg::ST_END:
          if (i_cmd_done)
            state_q <= stream_log_pkg::ST_IDLE;
        default:
          state_q <= stream_log_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      sel_q <= stream_log_pkg::LOG_DIRECTORY;
    else if (state_q == stream_log_pkg::ST_IDLE && i_req.valid && addr_ok)
      sel_q <= i_req.log_addr;
  end

  // Byte pointer and the byte on offer
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      ptr_q  <= 9'h000;
      byte_q <= 8'h00;
    end
    else if (state_q == stream_log_pkg::ST_LOAD)
    begin
      ptr_q  <= 9'h000;
      byte_q <= page_byte;
    end
    else if (advance)
    begin
      ptr_q  <= fetch_ptr;
      byte_q <= page_byte;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      reject_q <= 1'b0;
    else
      reject_q <= state_q == stream_log_pkg::ST_IDLE && i_req.valid && !addr_ok;
  end

  assign o_req_ready   = state_q == stream_log_pkg::ST_IDLE;
  assign o_req_reject  = reject_q;
  assign o_byte        = byte_q;
  assign o_byte_valid  = state_q == stream_log_pkg::ST_SEND;
  assign o_byte_last   = state_q == stream_log_pkg::ST_SEND && ptr_q == PAGE_LAST;
  assign o_write_index = store_index[0];
  assign o_write_count = store_count[0];
  assign o_read_index  = store_index[1];
  assign o_read_count  = store_count[1];

  sequence req_taken_s;
    o_req_ready && i_req.valid && addr_ok;
  endsequence

  sequence first_byte_s;
    !o_byte_valid ##1 (o_byte_valid && ptr_q == 9'h000);
  endsequence

  serve_start_a : assert property (@(posedge i_clk) disable iff (i_reset)
    req_taken_s |=> first_byte_s)
    else $error("page not offered two cycles after request");

  reject_bad_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (o_req_ready && i_req.valid && !addr_ok) |=> (o_req_reject && o_req_ready))
    else $error("unsupported log not rejected");

  page_end_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (o_byte_last && i_byte_ready) |=> (!o_byte_valid && !o_req_ready))
    else $error("page did not end after byte 511");

  clear_cause_a : assert property (@(posedge i_clk) disable iff (i_reset)
    clear[0] |-> (i_cmd_good && sel_q == stream_log_pkg::LOG_WRITE_STREAM && ptr_q == 9'h1ff))
    else $error("write log cleared without good read");

  read_clear_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (clear[1] && !i_evt.valid) |=> (o_read_index == 5'h00 && o_read_count == 16'h0000))
    else $error("read log not reset after good read");

  version_byte_a : assert property (@(posedge i_clk) disable iff (i_reset)
    ($past(state_q) == stream_log_pkg::ST_LOAD && (sel_q == stream_log_pkg::LOG_READ_STREAM
     || sel_q == stream_log_pkg::LOG_WRITE_STREAM))
    |-> o_byte == 8'h02)
    else $error("stream log version byte wrong");

  byte_hold_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (o_byte_valid && !i_byte_ready) |=> (o_byte_valid && $stable(o_byte) && $stable(ptr_q)))
    else $error("offered byte changed while stalled");

  byte_step_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (o_byte_valid && i_byte_ready && !o_byte_last)
    |=> (o_byte_valid && ptr_q == $past(ptr_q) + 9'h001))
    else $error("page pointer did not step by one");

  end_waits_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (state_q == stream_log_pkg::ST_END && !i_cmd_done) |=> state_q == stream_log_pkg::ST_END)
    else $error("left page end before completion");

  end_idle_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (state_q == stream_log_pkg::ST_END && i_cmd_done) |=> o_req_ready)
    else $error("not ready after completion");

  reject_cause_a : assert property (@(posedge i_clk) disable iff (i_reset)
    o_req_reject |-> $past(o_req_ready && i_req.valid && !addr_ok))
    else $error("reject without unsupported request");

  write_clear_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (clear[0] && !i_evt.valid) |=> (o_write_index == 5'h00 && o_write_count == 16'h0000))
    else $error("write log not reset after good read");

  read_event_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (i_evt.valid && !i_evt.is_write && i_evt.status[stream_log_pkg::STATUS_STREAM_ERR_BIT])
    |=> o_read_index != 5'h00)
    else $error("read index zero after logged error");

  read_count_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (i_evt.valid && !i_evt.is_write && i_evt.status[stream_log_pkg::STATUS_STREAM_ERR_BIT]
     && o_read_count != 16'hffff && !clear[1])
    |=> o_read_count == $past(o_read_count) + 16'h0001)
    else $error("read error not counted");

  write_count_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (i_evt.valid && i_evt.is_write && i_evt.status[stream_log_pkg::STATUS_STREAM_ERR_BIT]
     && o_write_count != 16'hffff && !clear[0])
    |=> o_write_count == $past(o_write_count) + 16'h0001)
    else $error("write error not counted");

  write_sat_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (o_write_count == 16'hffff && !clear[0]) |=> o_write_count == 16'hffff)
    else $error("write error counter wrapped");

  unflagged_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (i_evt.valid && !i_evt.status[stream_log_pkg::STATUS_STREAM_ERR_BIT] && clear == 2'b00)
    |=> ($stable(o_read_count) && $stable(o_write_count)))
    else $error("unflagged command was counted");

  dir_version_a : assert property (@(posedge i_clk) disable iff (i_reset)
    ($past(state_q) == stream_log_pkg::ST_LOAD && sel_q == stream_log_pkg::LOG_DIRECTORY)
    |-> o_byte == 8'h01)
    else $error("directory version byte wrong");

endmodule

// file: verilog/stream_log_pkg.sv
package stream_log_pkg;

  // Log addresses served by the keeper
  localparam logic [7:0]  LOG_DIRECTORY        = 8'h00;
  localparam logic [7:0]  LOG_PERF             = 8'h20;
  localparam logic [7:0]  LOG_WRITE_STREAM     = 8'h21;
  localparam logic [7:0]  LOG_READ_STREAM      = 8'h22;

  // Page geometry
  localparam int          PAGE_BYTES           = 512;
  localparam logic [8:0]  PAGE_LAST            = 9'h1ff;
  localparam int          MAX_ENTRIES          = 31;
  localparam int          ENTRY_BYTES          = 16;
  localparam logic [7:0]  PAGE_VERSION         = 8'h02;
  localparam logic [8:0]  OFS_VERSION          = 9'h000;
  localparam logic [8:0]  OFS_INDEX            = 9'h001;
  localparam logic [8:0]  OFS_COUNT_LO         = 9'h002;
  localparam logic [8:0]  OFS_COUNT_HI         = 9'h003;
  localparam logic [4:0]  IDX_EMPTY            = 5'h00;
  localparam logic [15:0] COUNT_MAX            = 16'hffff;

  // Byte positions inside one entry
  localparam int          ENT_FEAT_CUR         = 0;
  localparam int          ENT_FEAT_PREV        = 1;
  localparam int          ENT_STATUS           = 2;
  localparam int          ENT_ERROR            = 3;
  localparam int          ENT_LBA              = 4;
  localparam int          ENT_NSECT            = 12;
  localparam logic [15:0] DEFERRED_FEATURES    = 16'hffff;
  localparam int          STATUS_STREAM_ERR_BIT = 5;

  // Directory and performance page layout
  localparam logic [15:0] DIR_VERSION          = 16'h0001;
  localparam logic [15:0] PERF_SECTORS         = 16'h0001;
  localparam logic [15:0] STREAM_LOG_SECTORS   = 16'h0001;
  localparam logic [15:0] PERF_VERSION         = 16'h0001;
  localparam int          PERF_HDR_BYTES       = 8;
  localparam int          SECT_ENTRY_BYTES     = 8;
  localparam int          POS_ENTRY_BYTES      = 8;
  localparam int          ACC_ENTRY_BYTES      = 4;

  typedef struct packed {
    logic        valid;
    logic        is_write;
    logic        deferred;
    logic [7:0]  feat_cur;
    logic [7:0]  feat_prev;
    logic [7:0]  status;
    logic [7:0]  error;
    logic [47:0] lba;
    logic [15:0] nsect;
  } stream_err_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] log_addr;
  } log_req_s;

  typedef enum {
    ST_IDLE,
    ST_LOAD,
    ST_SEND,
    ST_END
  } serve_state_e;

endpackage

// file: verilog/stream_log_store.sv
module stream_log_store #(
  parameter int ENTRIES = stream_log_pkg::MAX_ENTRIES
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_reset,
  input  wire logic                        i_log,
  input  wire stream_log_pkg::stream_err_s i_evt,
  input  wire logic                        i_clear,
  input  wire logic [8:0]                  i_offset,
  output logic      [7:0]                  o_byte,
  output logic      [4:0]                  o_index,
  output logic      [15:0]                 o_count
);

  logic [127:0]       ent_q [ENTRIES];
  logic [ENTRIES-1:0] used_q;
  logic [4:0]         index_q;
  logic [15:0]        count_q;
  logic [4:0]         index_d;
  logic [127:0]       new_entry;
  logic               take;

  // Only commands ending with the stream error flag are logged
  assign take = i_log && i_evt.status[stream_log_pkg::STATUS_STREAM_ERR_BIT];

  // Wrap to the oldest slot once full; a clear in the same cycle starts afresh
  always_comb
  begin
    if (i_clear || index_q == 5'(ENTRIES))
      index_d = 5'h01;
    else
      index_d = index_q + 5'h01;
  end

  always_comb
  begin
    new_entry = '0;
    new_entry[stream_log_pkg::ENT_FEAT_CUR*8 +: 8]  = i_evt.feat_cur;
    new_entry[stream_log_pkg::ENT_FEAT_PREV*8 +: 8] = i_evt.feat_prev;
    if (i_evt.deferred)
      new_entry[stream_log_pkg::ENT_FEAT_CUR*8 +: 16] = stream_log_pkg::DEFERRED_FEATURES;
    new_entry[stream_log_pkg::ENT_STATUS*8 +: 8]    = i_evt.status;
    new_entry[stream_log_pkg::ENT_ERROR*8 +: 8]     = i_evt.error;
    new_entry[stream_log_pkg::ENT_LBA*8 +: 48]      = i_evt.lba;
    new_entry[stream_log_pkg::ENT_NSECT*8 +: 16]    = i_evt.nsect;
  end

  // Index of newest entry; event wins over a clear in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      index_q <= stream_log_pkg::IDX_EMPTY;
    else if (take)
      index_q <= index_d;
    else if (i_clear)
      index_q <= stream_log_pkg::IDX_EMPTY;
  end

  // Saturating error counter
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      count_q <= '0;
    else if (take)
    begin
      if (i_clear)
        count_q <= 16'h0001;
      else if (count_q != stream_log_pkg::COUNT_MAX)
        count_q <= count_q + 16'h0001;
    end
    else if (i_clear)
      count_q <= '0;
  end

  // Occupied slots; empty ones read as zero
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      used_q <= '0;
    else if (take)
      used_q <= (i_clear ? '0 : used_q) | (ENTRIES'(1) << (index_d - 5'h01));
    else if (i_clear)
      used_q <= '0;
  end

  for (genvar g = 0; g < ENTRIES; g++)
  begin : g_entry
    always_ff @(posedge i_clk)
    begin
      if (i_reset)
        ent_q[g] <= '0;
      else if (take && index_d == 5'(g + 1))
        ent_q[g] <= new_entry;
    end
  end

  // Page image: header, then entry n at byte n*16
  always_comb
  begin
    o_byte = 8'h00;
    if (i_offset[8:4] == 5'h00)
    begin
      case (i_offset)
        stream_log_pkg::OFS_VERSION:  o_byte = stream_log_pkg::PAGE_VERSION;
        stream_log_pkg::OFS_INDEX:    o_byte = {3'h0, index_q};
        stream_log_pkg::OFS_COUNT_LO: o_byte = count_q[7:0];
        stream_log_pkg::OFS_COUNT_HI: o_byte = count_q[15:8];
        default:                      o_byte = 8'h00;
      endcase
    end
    else if (used_q[i_offset[8:4] - 5'h01])
      o_byte = ent_q[i_offset[8:4] - 5'h01][{i_offset[3:0], 3'h0} +: 8];
  end

  assign o_index = index_q;
  assign o_count = count_q;

  index_range_a : assert property (@(posedge i_clk) disable iff (i_reset)
    index_q <= 5'(ENTRIES))
    else $error("log index out of range");

  count_sat_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (count_q == stream_log_pkg::COUNT_MAX && !i_clear) |=> count_q == 16'hffff)
    else $error("error counter wrapped");

  clear_resets_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (i_clear && !take) |=> (index_q == 5'h00 && count_q == 16'h0000 && used_q == '0))
    else $error("log not reset by clear");

  set_wins_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (i_clear && take) |=> (index_q == 5'h01 && count_q == 16'h0001))
    else $error("event lost against clear");

  only_flagged_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (!take && !i_clear) |=> $stable(count_q) && $stable(index_q))
    else $error("log changed without flagged error");

endmodule
